// >>> lot_top.sv
// Logic output four and analog-carried digital output with on-delay, hold and polarity
// Notes on behaviour
// - A condition turning true changes the output only after on-delay free-running ms ticks, so up to 1 ms early, 0 to 60000 ms.
// - A condition turning false keeps the output active until the hold time, 0 to 9999 ms.
// - Drive fault, brake, output, precharge and line contactor codes force on-delay to zero.
// - Drive fault and line contactor codes force the hold time to zero and ignore writes.
// - Positive polarity drives one while active, negative polarity drives zero while active.
// - Drive fault, brake, precharge and line contactor codes fix polarity at positive.
// - In digital mode the first analog output sits at its minimum for zero, maximum for one.
// - The carried output adds brake to wobble codes, settable only via application config.
//
// Implementation choices: strobed register access and the register offsets.
`timescale 1ns/100ps

module lot_top #(
	parameter int MS_CYCLES = lot_pkg::MS_CYCLES,
	parameter int NUM_COND = 32
) (
	// Clock, reset, enable
	input wire logic clk,
	input wire logic srst,
	input wire logic ce,
	// Register port
	input wire logic [lot_pkg::ADDR_W-1:0] addr,
	input wire logic [lot_pkg::DATA_W-1:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [lot_pkg::DATA_W-1:0] rdata,
	// Application-function configuration of the carried output
	input wire logic app_wr,
	input wire logic [lot_pkg::CODE_W-1:0] app_assign,
	// Internal conditions and analog value
	input wire logic [NUM_COND-1:0] cond_in,
	input wire logic [lot_pkg::LEVEL_W-1:0] analog_level,
	// Outputs
	output logic logic_output_four,
	output logic analog_carried_digital_out,
	output logic [lot_pkg::LEVEL_W-1:0] first_analog_output
);

	////////////////////////////////////////////////////////////////////////////
	// Configuration state
	logic [lot_pkg::NUM_CH-1:0][lot_pkg::CODE_W-1:0] assign_code;
	logic [lot_pkg::NUM_CH-1:0][lot_pkg::DELAY_W-1:0] on_delay;
	logic [lot_pkg::NUM_CH-1:0][lot_pkg::HOLD_W-1:0] hold_time;
	logic [lot_pkg::NUM_CH-1:0] active_low_polarity;
	logic [lot_pkg::LEVEL_W-1:0] ao_min;
	logic [lot_pkg::LEVEL_W-1:0] ao_max;

	// Timing state
	logic [lot_pkg::NUM_CH-1:0] active;
	logic [lot_pkg::NUM_CH-1:0][lot_pkg::DELAY_W-1:0] elapsed;
	logic [lot_pkg::DELAY_W-1:0] prescale;
	logic ms_tick;

	// Decoded and effective values
	logic [lot_pkg::NUM_CH-1:0] ch_hit;
	logic [1:0] reg_sel;
	logic [lot_pkg::NUM_CH-1:0] cond;
	logic [lot_pkg::NUM_CH-1:0][lot_pkg::DELAY_W-1:0] eff_delay;
	logic [lot_pkg::NUM_CH-1:0][lot_pkg::DELAY_W-1:0] eff_hold;
	logic [lot_pkg::NUM_CH-1:0][lot_pkg::DELAY_W-1:0] limit;
	logic [lot_pkg::NUM_CH-1:0] next_active;
	logic [lot_pkg::DATA_W-1:0] next_rdata;

	////////////////////////////////////////////////////////////////////////////
	// Address decode
	always_comb
	begin
		ch_hit[0] = (addr[7:4] == lot_pkg::CH0_BASE[7:4]);
		ch_hit[1] = (addr[7:4] == lot_pkg::CH1_BASE[7:4]);
		reg_sel = addr[3:2];
	end

	////////////////////////////////////////////////////////////////////////////
	// Channel configuration; forced values are cleared so reads show what applies
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			for (int c = 0; c < lot_pkg::NUM_CH; c++)
			begin
				assign_code[c] <= lot_pkg::RST_ASSIGN;
				on_delay[c] <= lot_pkg::RST_DELAY;
				hold_time[c] <= lot_pkg::RST_HOLD;
				active_low_polarity[c] <= lot_pkg::RST_POL;
			end
		end
		else if (ce)
		begin
			for (int c = 0; c < lot_pkg::NUM_CH; c++)
			begin
				// Software never selects the application-only codes
				if (wr && ch_hit[c] && reg_sel == lot_pkg::REG_ASSIGN &&
					!lot_pkg::app_only(wdata[lot_pkg::CODE_W-1:0]))
					assign_code[c] <= wdata[lot_pkg::CODE_W-1:0];
				else if (c == 1 && app_wr)
					assign_code[c] <= app_assign;
				if (lot_pkg::forces_delay(assign_code[c]))
					on_delay[c] <= '0;
				else if (wr && ch_hit[c] && reg_sel == lot_pkg::REG_DELAY &&
					wdata[lot_pkg::DATA_W-1:lot_pkg::DELAY_W] == '0 &&
					wdata[lot_pkg::DELAY_W-1:0] <= lot_pkg::DELAY_MAX_MS)
					on_delay[c] <= wdata[lot_pkg::DELAY_W-1:0];
				if (lot_pkg::forces_hold(assign_code[c]))
					hold_time[c] <= '0;
				else if (wr && ch_hit[c] && reg_sel == lot_pkg::REG_HOLD &&
					wdata[lot_pkg::DATA_W-1:lot_pkg::HOLD_W] == '0 &&
					wdata[lot_pkg::HOLD_W-1:0] <= lot_pkg::HOLD_MAX_MS)
					hold_time[c] <= wdata[lot_pkg::HOLD_W-1:0];
				if (lot_pkg::forces_pol(assign_code[c]))
					active_low_polarity[c] <= 1'b0;
				else if (wr && ch_hit[c] && reg_sel == lot_pkg::REG_POL)
					active_low_polarity[c] <= wdata[0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Analog output limits
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			ao_min <= lot_pkg::RST_AO_MIN;
			ao_max <= lot_pkg::RST_AO_MAX;
		end
		else if (ce && wr)
		begin
			if (addr == lot_pkg::AO_MIN_OFS)
				ao_min <= wdata[lot_pkg::LEVEL_W-1:0];
			if (addr == lot_pkg::AO_MAX_OFS)
				ao_max <= wdata[lot_pkg::LEVEL_W-1:0];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Millisecond time base
	always_ff @(posedge clk)
	begin
		if (srst)
			prescale <= '0;
		else if (ce)
		begin
			if (ms_tick)
				prescale <= '0;
			else
				prescale <= prescale + 16'h0001;
		end
	end

	assign ms_tick = (prescale == lot_pkg::DELAY_W'(MS_CYCLES - 1));

	////////////////////////////////////////////////////////////////////////////
	// Effective times; forced codes act at once, before the stored value clears
	always_comb
	begin
		for (int c = 0; c < lot_pkg::NUM_CH; c++)
		begin
			cond[c] = (assign_code[c] != lot_pkg::CODE_NONE) &&
				cond_in[assign_code[c]];
			eff_delay[c] = lot_pkg::forces_delay(assign_code[c]) ? '0 : on_delay[c];
			eff_hold[c] = lot_pkg::forces_hold(assign_code[c]) ? '0 :
				{2'h0, hold_time[c]};
			limit[c] = active[c] ? eff_hold[c] : eff_delay[c];
			next_active[c] = active[c];
			if (cond[c] != active[c] && elapsed[c] >= limit[c])
				next_active[c] = cond[c];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Delay and hold timers; the count restarts whenever the condition bounces back
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			active <= '0;
			elapsed <= '0;
		end
		else if (ce)
		begin
			for (int c = 0; c < lot_pkg::NUM_CH; c++)
			begin
				active[c] <= next_active[c];
				if (cond[c] == active[c] || next_active[c] != active[c])
					elapsed[c] <= '0;
				else if (ms_tick)
					elapsed[c] <= elapsed[c] + 16'h0001;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Output drivers
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			logic_output_four <= 1'b0;
			analog_carried_digital_out <= 1'b0;
			first_analog_output <= '0;
		end
		else if (ce)
		begin
			logic_output_four <= active[0] ^ active_low_polarity[0];
			analog_carried_digital_out <= active[1] ^ active_low_polarity[1];
			// Unassigned carried channel leaves the output analog
			if (assign_code[1] == lot_pkg::CODE_NONE)
				first_analog_output <= analog_level;
			else if (active[1] ^ active_low_polarity[1])
				first_analog_output <= ao_max;
			else
				first_analog_output <= ao_min;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Register read; unmapped addresses read zero
	always_comb
	begin
		next_rdata = '0;
		for (int c = 0; c < lot_pkg::NUM_CH; c++)
		begin
			if (ch_hit[c])
			begin
				unique case (reg_sel)
					lot_pkg::REG_ASSIGN: next_rdata[lot_pkg::CODE_W-1:0] = assign_code[c];
					lot_pkg::REG_DELAY: next_rdata[lot_pkg::DELAY_W-1:0] = on_delay[c];
					lot_pkg::REG_HOLD: next_rdata[lot_pkg::HOLD_W-1:0] = hold_time[c];
					lot_pkg::REG_POL: next_rdata[0] = active_low_polarity[c];
				endcase
			end
		end
		if (addr == lot_pkg::AO_MIN_OFS)
			next_rdata[lot_pkg::LEVEL_W-1:0] = ao_min;
		if (addr == lot_pkg::AO_MAX_OFS)
			next_rdata[lot_pkg::LEVEL_W-1:0] = ao_max;
		if (addr == lot_pkg::STATUS_OFS)
			next_rdata[5:0] = {analog_carried_digital_out, logic_output_four, cond, active};
	end

	always_ff @(posedge clk)
	begin
		if (srst)
			rdata <= '0;
		else if (ce)
			rdata <= rd ? next_rdata : '0;
	end

	////////////////////////////////////////////////////////////////////////////
	// Ticks since the output four condition last changed, counted apart from the timer
	logic cond_seen;
	logic [lot_pkg::DELAY_W-1:0] ticks_seen;

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			cond_seen <= 1'b0;
			ticks_seen <= '0;
		end
		else if (ce)
		begin
			cond_seen <= cond[0];
			if (cond[0] != cond_seen)
				ticks_seen <= ms_tick ? 16'h0001 : 16'h0000;
			else if (ms_tick)
				ticks_seen <= ticks_seen + 16'h0001;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (srst);

	// Reset itself is the antecedent here, so the default disable must not apply
	reset_defaults_a: assert property (disable iff (1'b0) srst |=>
		assign_code == '0 && on_delay == '0 && hold_time == '0 && active_low_polarity == '0)
		else $error("channel not at defaults after reset");

	on_delay_a: assert property (ce && !active[0] && next_active[0] |->
		cond[0] && (lot_pkg::forces_delay(assign_code[0]) || ticks_seen >= on_delay[0]))
		else $error("output four activated before on-delay");

	hold_time_a: assert property (ce && active[1] && !next_active[1] |->
		!cond[1] && elapsed[1] >= eff_hold[1])
		else $error("carried output released before hold time");

	forced_delay_a: assert property (ce && lot_pkg::forces_delay(assign_code[0])
		|=> on_delay[0] == '0)
		else $error("forced on-delay not zero");

	forced_hold_a: assert property (ce && lot_pkg::forces_hold(assign_code[1])
		|=> hold_time[1] == '0)
		else $error("forced hold time not zero");

	polarity_out_a: assert property (ce |=>
		logic_output_four == $past(active[0] ^ active_low_polarity[0]))
		else $error("output four polarity wrong");

	forced_pol_a: assert property (ce && lot_pkg::forces_pol(assign_code[1])
		|=> !active_low_polarity[1])
		else $error("forced polarity not positive");

	analog_level_a: assert property (ce && assign_code[1] != '0 |=>
		first_analog_output == ($past(active[1] ^ active_low_polarity[1]) ?
		$past(ao_max) : $past(ao_min)))
		else $error("analog output not at limit");

	app_only_a: assert property (ce && wr && ch_hit[0] && reg_sel == lot_pkg::REG_ASSIGN &&
		lot_pkg::app_only(wdata[lot_pkg::CODE_W-1:0]) |=> $stable(assign_code[0]))
		else $error("application-only code accepted from software");

	delayed_on_c: cover property (ce && !active[0] && next_active[0] && eff_delay[0] != '0);
	held_off_c: cover property (ce && active[1] && !next_active[1] && eff_hold[1] != '0);
	negative_c: cover property (active_low_polarity[0] && active[0]);
	app_assign_c: cover property (app_wr && lot_pkg::app_only(app_assign));

endmodule : lot_top

// >>> lot_pkg.sv
// Package: constants, codes and helper functions for the logic output timing block
package lot_pkg;

	////////////////////////////////////////////////////////////////////////////
	// Widths
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int CODE_W = 5;
	localparam int DELAY_W = 16;
	localparam int HOLD_W = 14;
	localparam int LEVEL_W = 12;
	localparam int NUM_CH = 2;

	////////////////////////////////////////////////////////////////////////////
	// Register offsets; channel 0 at CH0_BASE, channel 1 at CH1_BASE
	localparam logic [7:0] CH0_BASE = 8'h00;
	localparam logic [7:0] CH1_BASE = 8'h10;
	localparam logic [1:0] REG_ASSIGN = 2'h0;
	localparam logic [1:0] REG_DELAY = 2'h1;
	localparam logic [1:0] REG_HOLD = 2'h2;
	localparam logic [1:0] REG_POL = 2'h3;
	localparam logic [7:0] AO_MIN_OFS = 8'h20;
	localparam logic [7:0] AO_MAX_OFS = 8'h24;
	localparam logic [7:0] STATUS_OFS = 8'h28;

	////////////////////////////////////////////////////////////////////////////
	// Ranges and reset values
	localparam logic [DELAY_W-1:0] DELAY_MAX_MS = 16'hea60;
	localparam logic [HOLD_W-1:0] HOLD_MAX_MS = 14'h270f;
	localparam logic [CODE_W-1:0] RST_ASSIGN = 5'h00;
	localparam logic [DELAY_W-1:0] RST_DELAY = 16'h0000;
	localparam logic [HOLD_W-1:0] RST_HOLD = 14'h0000;
	localparam logic RST_POL = 1'b0;
	localparam logic [LEVEL_W-1:0] RST_AO_MIN = 12'h000;
	localparam logic [LEVEL_W-1:0] RST_AO_MAX = 12'hfff;

	////////////////////////////////////////////////////////////////////////////
	// Time base
	localparam int CLK_PERIOD_PS = 25000;
	localparam int MS_PS = 1000000000;
	localparam int MS_CYCLES = MS_PS / CLK_PERIOD_PS;

	////////////////////////////////////////////////////////////////////////////
	// Assignment codes
	typedef enum logic [CODE_W-1:0] {
		CODE_NONE = 5'h00,
		CODE_DRIVE_FAULT = 5'h01,
		CODE_BRAKE = 5'h02,
		CODE_LINE_CONT = 5'h03,
		CODE_OUT_CONT = 5'h04,
		CODE_PRECHARGE = 5'h05,
		CODE_END_REEL = 5'h06,
		CODE_WOBBLE = 5'h07
	} lot_code_t;

	function automatic logic forces_delay(input logic [CODE_W-1:0] c);
		forces_delay = (c >= CODE_DRIVE_FAULT) && (c <= CODE_PRECHARGE);
	endfunction : forces_delay

	function automatic logic forces_hold(input logic [CODE_W-1:0] c);
		forces_hold = (c == CODE_DRIVE_FAULT) || (c == CODE_LINE_CONT);
	endfunction : forces_hold

	function automatic logic forces_pol(input logic [CODE_W-1:0] c);
		forces_pol = forces_delay(c) && (c != CODE_OUT_CONT);
	endfunction : forces_pol

	function automatic logic app_only(input logic [CODE_W-1:0] c);
		app_only = (c >= CODE_BRAKE) && (c <= CODE_WOBBLE);
	endfunction : app_only

endpackage : lot_pkg

// >>> lot_load_model.sv
// Behavioural contactor load hanging on a relay-style output
`timescale 1ns/100ps

module lot_load_model #(
	parameter int PICKUP = 2
) (
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	// Coil drive from the block
	input wire logic coil,
	// Contact state seen by the plant
	output logic energised
);

	int cnt;

	////////////////////////////////////////////////////////////////////////////
	// Contact closes only after the coil stayed on for the pickup time; drops at once
	always_ff @(posedge clk)
	begin
		if (srst || !coil)
		begin
			cnt <= 0;
			energised <= 1'b0;
		end
		else if (cnt < PICKUP)
			cnt <= cnt + 1;
		else
			energised <= 1'b1;
	end

endmodule : lot_load_model

// >>> lot_tb.sv
// Self-checking testbench for the logic output timing block
`timescale 1ns/100ps

module testbench;

	localparam int MSC = 4;
	typedef struct packed {logic [7:0] a; logic w; logic [31:0] v;} lot_row_t;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic ce = 1'b1;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [31:0] rdata;
	logic app_wr = 1'b0;
	logic [4:0] app_assign = 5'h00;
	logic [31:0] cond_in = 32'h0;
	logic [11:0] analog_level = 12'h5a5;
	logic lo4;
	logic cdo;
	logic [11:0] ao;
	logic coil_on;
	int err_total = 0;
	int num_checks = 0;
	string pname [4] = '{"output four", "carried out", "analog out", "load contact"};
	lot_row_t rows [20] = '{
		'{8'h00, 1'b0, 32'h0}, '{8'h04, 1'b0, 32'h0}, '{8'h08, 1'b0, 32'h0},
		'{8'h0c, 1'b0, 32'h0}, '{8'h10, 1'b0, 32'h0}, '{8'h1c, 1'b0, 32'h0},
		'{8'h24, 1'b0, 32'hfff}, '{8'h04, 1'b1, 32'hea60}, '{8'h04, 1'b1, 32'hea61},
		'{8'h04, 1'b0, 32'hea60}, '{8'h08, 1'b1, 32'h270f}, '{8'h08, 1'b1, 32'h2710},
		'{8'h08, 1'b0, 32'h270f}, '{8'h0c, 1'b1, 32'h1}, '{8'h0c, 1'b0, 32'h1},
		'{8'h00, 1'b1, 32'h2}, '{8'h00, 1'b0, 32'h0}, '{8'h10, 1'b1, 32'h6},
		'{8'h10, 1'b0, 32'h0}, '{8'h30, 1'b0, 32'h0}};

	always #12.5 clk = ~clk;

	lot_top #(.MS_CYCLES(MSC), .NUM_COND(32)) DUT (.clk(clk), .srst(srst), .ce(ce),
		.addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .app_wr(app_wr),
		.app_assign(app_assign), .cond_in(cond_in), .analog_level(analog_level),
		.logic_output_four(lo4), .analog_carried_digital_out(cdo), .first_analog_output(ao));

	lot_load_model #(.PICKUP(2)) load (.clk(clk), .srst(srst), .coil(lo4), .energised(coil_on));

	////////////////////////////////////////////////////////////////////////////
	task automatic chk_reg(input logic [7:0] a, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e)
		begin
			err_total++;
			$display("[ERR] reg %h expected %h seen %h", a, e, g);
		end
	endtask : chk_reg

	task automatic chk_pin(input int s, input logic [11:0] e, input logic [11:0] g);
		num_checks++;
		if (g !== e)
		begin
			err_total++;
			$display("[ERR] %s expected %h seen %h", pname[s], e, g);
		end
	endtask : chk_pin

	task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask : bus_wr

	// Read data are taken in the one cycle after the strobe, the only cycle they stand
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		chk_reg(a, e, rdata);
	endtask : rd_chk

	task automatic app_set(input logic [4:0] c);
		@(posedge clk);
		app_assign <= c;
		app_wr <= 1'b1;
		@(posedge clk);
		app_wr <= 1'b0;
	endtask : app_set

	function automatic logic [11:0] pin(input int s);
		case (s)
			0: pin = {11'h000, lo4};
			1: pin = {11'h000, cdo};
			2: pin = ao;
			default: pin = {11'h000, coil_on};
		endcase
	endfunction : pin

	// Bounded wait; the tick phase is free running, so only bounds are exact
	task automatic wait_pin(input int s, input logic [11:0] v, input int maxc);
		int n;
		n = 0;
		#1;
		while (pin(s) !== v && n < maxc)
		begin
			@(posedge clk);
			#1;
			n++;
		end
		chk_pin(s, v, pin(s));
	endtask : wait_pin

	task automatic set_cond(input int i, input logic v);
		@(posedge clk);
		cond_in[i] <= v;
	endtask : set_cond

	task results();
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : results

	////////////////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (20) @(posedge clk);
		srst <= 1'b0;
		foreach (rows[i])
		begin
			if (rows[i].w)
				bus_wr(rows[i].a, rows[i].v);
			else
				rd_chk(rows[i].a, rows[i].v);
		end
		$display("test register table done");
		bus_wr(8'h00, 32'h8);
		bus_wr(8'h04, 32'h3);
		bus_wr(8'h08, 32'h2);
		bus_wr(8'h0c, 32'h0);
		set_cond(8, 1'b1);
		repeat (2 * MSC) @(posedge clk);
		#1;
		chk_pin(0, 12'h000, pin(0));
		wait_pin(0, 12'h001, 2 * MSC + 4);
		set_cond(8, 1'b0);
		repeat (MSC) @(posedge clk);
		#1;
		chk_pin(0, 12'h001, pin(0));
		wait_pin(0, 12'h000, 2 * MSC + 4);
		$display("test delay and hold done");
		bus_wr(8'h0c, 32'h1);
		bus_wr(8'h04, 32'h0);
		wait_pin(0, 12'h001, 3);
		set_cond(8, 1'b1);
		wait_pin(0, 12'h000, 3);
		set_cond(8, 1'b0);
		wait_pin(0, 12'h001, 3 * MSC + 4);
		$display("test polarity done");
		// Drive fault over a stored negative polarity and a stored hold time
		bus_wr(8'h00, 32'h1);
		bus_wr(8'h04, 32'h7);
		rd_chk(8'h04, 32'h0);
		rd_chk(8'h08, 32'h0);
		rd_chk(8'h0c, 32'h0);
		set_cond(1, 1'b1);
		wait_pin(0, 12'h001, 3);
		wait_pin(3, 12'h001, 4);
		set_cond(1, 1'b0);
		wait_pin(0, 12'h000, 3);
		for (int c = 1; c < 8; c++)
		begin
			app_set(c[4:0]);
			bus_wr(8'h14, 32'h5);
			bus_wr(8'h18, 32'h5);
			bus_wr(8'h1c, 32'h1);
			rd_chk(8'h10, c);
			rd_chk(8'h14, (c <= 5) ? 32'h0 : 32'h5);
			rd_chk(8'h18, (c == 1 || c == 3) ? 32'h0 : 32'h5);
			rd_chk(8'h1c, (c == 4 || c > 5) ? 32'h1 : 32'h0);
		end
		$display("test forced settings done");
		app_set(5'h09);
		bus_wr(8'h14, 32'h0);
		bus_wr(8'h18, 32'h0);
		bus_wr(8'h1c, 32'h0);
		bus_wr(8'h20, 32'h123);
		bus_wr(8'h24, 32'habc);
		wait_pin(2, 12'h123, 3);
		set_cond(9, 1'b1);
		wait_pin(1, 12'h001, 3);
		wait_pin(2, 12'habc, 3);
		bus_wr(8'h1c, 32'h1);
		wait_pin(1, 12'h000, 3);
		wait_pin(2, 12'h123, 3);
		$display("test carried output done");
		// Clock enable low freezes the carried channel in the middle of a release
		@(posedge clk);
		ce <= 1'b0;
		cond_in[9] <= 1'b0;
		repeat (2 * MSC) @(posedge clk);
		#1;
		chk_pin(1, 12'h000, pin(1));
		@(posedge clk);
		ce <= 1'b1;
		wait_pin(1, 12'h001, 3);
		$display("test clock enable done");
		@(posedge clk);
		srst <= 1'b1;
		repeat (2) @(posedge clk);
		srst <= 1'b0;
		wait_pin(1, 12'h000, 1);
		wait_pin(2, 12'h5a5, 2);
		rd_chk(8'h10, 32'h0);
		rd_chk(8'h1c, 32'h0);
		$display("test second reset done");
		results();
	end

	// Whole run needs well under two thousand cycles
	initial
	begin
		repeat (20000) @(posedge clk);
		err_total++;
		$display("[ERR] watchdog expected end of run seen timeout");
		results();
	end

endmodule : testbench
